// [src/eag_top.sv]
// Effective address generator with pointer, offset and modifier files
`include "eag_defs.svh"
module eag_top (
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    input  wire logic                    req_valid,
    input  wire eag_pkg::eag_mode_t      req_mode,
    input  wire logic [`EAG_IDXW-1:0]    req_ptr,
    input  wire logic [`EAG_FIELD_W-1:0] req_field,
    input  wire logic [`EAG_AW-1:0]      req_ext,
    input  wire logic [`EAG_AW-1:0]      req_pc,
    input  wire logic                    sixteen_bit_compat_mode,
    input  wire logic                    wr_en,
    input  wire eag_pkg::eag_wrsel_t     wr_sel,
    input  wire logic [`EAG_IDXW-1:0]    wr_idx,
    input  wire logic [`EAG_AW-1:0]      wr_data,
    output logic                         ea_valid_q,
    output logic [`EAG_AW-1:0]           ea_q,
    output logic                         ea_is_data_q,
    output logic                         wb_valid_q,
    output logic [`EAG_IDXW-1:0]         wb_idx_q,
    output logic [`EAG_AW-1:0]           wb_data_q
);
    import eag_pkg::*;

    localparam int NP = `EAG_NPTR;
    localparam int AW = `EAG_AW;

    logic [AW-1:0] address_pointer_q    [NP];
    logic [AW-1:0] address_pointer_d    [NP];
    logic [AW-1:0] pointer_offset_reg_q [NP];
    logic [AW-1:0] pointer_offset_reg_d [NP];
    logic [AW-1:0] pointer_modifier_reg_q [NP];
    logic [AW-1:0] pointer_modifier_reg_d [NP];

    logic [AW-1:0]         sel_ptr;
    logic [AW-1:0]         sel_ofs;
    logic [AW-1:0]         sel_mod;
    logic                  wb_fire;
    logic                  ea_valid_d;
    logic [AW-1:0]         ea_d;
    logic                  ea_is_data_d;
    logic                  wb_valid_d;
    logic [`EAG_IDXW-1:0]  wb_idx_d;
    logic [AW-1:0]         wb_data_d;

    eag_arith_if ar ();

    eag_modarith u_arith (
        .ar (ar.unit)
    );

    assign sel_ptr = address_pointer_q[req_ptr];
    assign sel_ofs = pointer_offset_reg_q[req_ptr];
    assign sel_mod = pointer_modifier_reg_q[req_ptr];

    // operand address and pointer update, one pass per request
    always_comb begin
        ar.base_val  = sel_ptr;
        ar.step      = 24'h000001;
        ar.dec       = 1'b0;
        // the same modifier governs every indirect mode
        ar.modifier  = sel_mod;
        ea_d         = sel_ptr;
        ea_is_data_d = 1'b0;
        wb_fire      = 1'b0;
        case (req_mode)
            eag_m_noupd: begin
                ea_d = sel_ptr;
            end
            eag_m_postinc1: begin
                wb_fire = 1'b1;
            end
            eag_m_postdec1: begin
                ar.dec  = 1'b1;
                wb_fire = 1'b1;
            end
            eag_m_postincn: begin
                ar.step = sel_ofs;
                wb_fire = 1'b1;
            end
            eag_m_postdecn: begin
                ar.step = sel_ofs;
                ar.dec  = 1'b1;
                wb_fire = 1'b1;
            end
            eag_m_indexn: begin
                ar.step = sel_ofs;
                ea_d    = ar.result;
            end
            eag_m_predec: begin
                // same decremented value goes out and back in
                ar.dec  = 1'b1;
                wb_fire = 1'b1;
                ea_d    = ar.result;
            end
            eag_m_sdisp: begin
                if (sixteen_bit_compat_mode) begin
                    ar.step = {{(AW-`EAG_SC_W){1'b0}},
                               {(`EAG_SC_W-`EAG_SDISP_W){req_field[`EAG_SDISP_W-1]}},
                               req_field[`EAG_SDISP_W-1:0]};
                end else begin
                    ar.step = {{(AW-`EAG_SDISP_W){req_field[`EAG_SDISP_W-1]}},
                               req_field[`EAG_SDISP_W-1:0]};
                end
                ea_d = ar.result;
            end
            eag_m_ldisp: begin
                ar.step = req_ext;
                ea_d    = ar.result;
            end
            // pc-relative adds bypass the modifier unit
            eag_m_pc_short: begin
                ea_d = req_pc + {{(AW-`EAG_PCDISP_W){req_field[`EAG_PCDISP_W-1]}},
                                 req_field[`EAG_PCDISP_W-1:0]};
            end
            eag_m_pc_long: begin
                ea_d = req_pc + req_ext;
            end
            eag_m_pc_reg: begin
                ea_d = req_pc + sel_ptr;
            end
            eag_m_imm8: begin
                ea_d         = {{(AW-`EAG_IMM8_W){1'b0}}, req_field[`EAG_IMM8_W-1:0]};
                ea_is_data_d = 1'b1;
            end
            eag_m_imm12: begin
                ea_d         = {{(AW-`EAG_IMM12_W){1'b0}}, req_field[`EAG_IMM12_W-1:0]};
                ea_is_data_d = 1'b1;
            end
            eag_m_imm_long: begin
                ea_d         = req_ext;
                ea_is_data_d = 1'b1;
            end
            eag_m_abs_long: begin
                ea_d = req_ext;
            end
            eag_m_abs_short: begin
                ea_d = {{(AW-`EAG_ABS_W){1'b0}}, req_field[`EAG_ABS_W-1:0]};
            end
            eag_m_jump_short: begin
                ea_d = {{(AW-`EAG_JMP_W){1'b0}}, req_field[`EAG_JMP_W-1:0]};
            end
            eag_m_io_short: begin
                ea_d = {{(AW-`EAG_IO_W){1'b1}}, req_field[`EAG_IO_W-1:0]};
            end
            default: begin
                ea_d = sel_ptr;
            end
        endcase
        ea_valid_d = req_valid;
        wb_valid_d = req_valid & wb_fire;
        wb_idx_d   = req_ptr;
        wb_data_d  = ar.result;
        if (!req_valid) begin
            ea_d         = '0;
            ea_is_data_d = 1'b0;
            wb_data_d    = '0;
        end
    end

    // register file next state; a write-back beats a same-cycle load
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            address_pointer_d[i]      = address_pointer_q[i];
            pointer_offset_reg_d[i]   = pointer_offset_reg_q[i];
            pointer_modifier_reg_d[i] = pointer_modifier_reg_q[i];
        end
        if (wr_en) begin
            case (wr_sel)
                eag_wr_ptr: address_pointer_d[wr_idx]      = wr_data;
                eag_wr_ofs: pointer_offset_reg_d[wr_idx]   = wr_data;
                eag_wr_mod: pointer_modifier_reg_d[wr_idx] = wr_data;
                default:    ;
            endcase
        end
        if (wb_valid_d) begin
            address_pointer_d[req_ptr] = ar.result;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NP; i++) begin
                address_pointer_q[i]      <= '0;
                pointer_offset_reg_q[i]   <= '0;
                pointer_modifier_reg_q[i] <= `EAG_MOD_RESET;
            end
        end else begin
            for (int i = 0; i < NP; i++) begin
                address_pointer_q[i]      <= address_pointer_d[i];
                pointer_offset_reg_q[i]   <= pointer_offset_reg_d[i];
                pointer_modifier_reg_q[i] <= pointer_modifier_reg_d[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ea_valid_q   <= 1'b0;
            ea_q         <= '0;
            ea_is_data_q <= 1'b0;
            wb_valid_q   <= 1'b0;
            wb_idx_q     <= '0;
            wb_data_q    <= '0;
        end else begin
            ea_valid_q   <= ea_valid_d;
            ea_q         <= ea_d;
            ea_is_data_q <= ea_is_data_d;
            wb_valid_q   <= wb_valid_d;
            wb_idx_q     <= wb_idx_d;
            wb_data_q    <= wb_data_d;
        end
    end

    // checks on the registered answer
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    logic sel_linear;
    assign sel_linear = sel_mod[15:0] == `EAG_MOD_LINEAR;

    sequence s_req(eag_mode_t m);
        req_valid && !wr_en && req_mode == m;
    endsequence

    noupd_keeps_ptr_a: assert property (
        s_req(eag_m_noupd) |=> ea_valid_q && !wb_valid_q
            && ea_q == $past(sel_ptr)
            && address_pointer_q[$past(req_ptr)] == $past(sel_ptr))
        else $error("no-update mode changed pointer or address");

    // pointer checked in the answer cycle: a back-to-back request moves it again
    postinc_one_a: assert property (
        s_req(eag_m_postinc1) ##0 sel_linear |=> wb_valid_q
            && ea_q == $past(sel_ptr) && wb_data_q == $past(sel_ptr) + 24'h000001
            && address_pointer_q[$past(req_ptr)] == wb_data_q)
        else $error("post-increment by one wrong");

    postdec_ofs_a: assert property (
        s_req(eag_m_postdecn) ##0 sel_linear |=> wb_valid_q
            && ea_q == $past(sel_ptr) && wb_data_q == $past(sel_ptr) - $past(sel_ofs))
        else $error("post-decrement by offset wrong");

    indexed_sum_a: assert property (
        s_req(eag_m_indexn) ##0 sel_linear |=> !wb_valid_q
            && ea_q == $past(sel_ptr) + $past(sel_ofs))
        else $error("indexed address wrong or pointer written");

    predec_match_a: assert property (
        s_req(eag_m_predec) ##0 sel_linear |=> wb_valid_q
            && ea_q == wb_data_q && ea_q == $past(sel_ptr) - 24'h000001)
        else $error("pre-decrement address and write-back differ");

    pc_reg_sum_a: assert property (
        s_req(eag_m_pc_reg) |=> !wb_valid_q
            && ea_q == $past(req_pc) + $past(sel_ptr))
        else $error("pointer pc-relative address wrong");

    abs_short_a: assert property (
        s_req(eag_m_abs_short) |=> ea_q[AW-1:`EAG_ABS_W] == '0
            && ea_q[`EAG_ABS_W-1:0] == $past(req_field[`EAG_ABS_W-1:0]))
        else $error("absolute short not zero-extended");

    jump_short_a: assert property (
        s_req(eag_m_jump_short) |=> ea_q[AW-1:`EAG_JMP_W] == '0 && !ea_is_data_q
            && ea_q[`EAG_JMP_W-1:0] == $past(req_field))
        else $error("short jump address wrong");

    io_short_a: assert property (
        s_req(eag_m_io_short) |=> &ea_q[AW-1:`EAG_IO_W]
            && ea_q[`EAG_IO_W-1:0] == $past(req_field[`EAG_IO_W-1:0]))
        else $error("i/o short not one-extended");

    imm8_data_a: assert property (
        s_req(eag_m_imm8) |=> ea_is_data_q && ea_q[AW-1:`EAG_IMM8_W] == '0)
        else $error("short immediate not zero-extended data");

    postinc_ofs_a: assert property (
        s_req(eag_m_postincn) ##0 sel_linear |=> wb_valid_q
            && ea_q == $past(sel_ptr) && wb_data_q == $past(sel_ptr) + $past(sel_ofs))
        else $error("post-increment by offset wrong");

    pc_long_a: assert property (
        s_req(eag_m_pc_long) |=> !wb_valid_q && ea_q == $past(req_pc) + $past(req_ext))
        else $error("long pc-relative address wrong");

    pc_short_a: assert property (
        s_req(eag_m_pc_short) |=> ea_q - $past(req_pc)
            == {{(AW-`EAG_PCDISP_W){$past(req_field[`EAG_PCDISP_W-1])}},
                $past(req_field[`EAG_PCDISP_W-1:0])})
        else $error("short pc-relative address wrong");

    reset_linear_a: assert property (
        $rose(arst_n) |-> sel_mod == `EAG_MOD_RESET && ar.kind == eag_ar_linear)
        else $error("modifier not linear after reset");

    idle_quiet_a: assert property (
        !req_valid |=> !ea_valid_q && !wb_valid_q && ea_q == '0)
        else $error("answer without a request");
endmodule // eag_top

// [src/eag_defs.svh]
// Constants shared by the effective address generator
// What this block does
// - no-update indirect: pointer is the address, pointer kept.
// - post step by one: access at pointer, write back pointer plus/minus one.
// - post increment by offset: access at pointer, write back pointer plus offset.
// - post decrement by offset: access at pointer, write back pointer minus offset.
// - indexed: address is pointer plus offset, nothing written back.
// - pre-decrement: pointer minus one written back and used as address.
// - short displacement: sign-extend seven bits (16 in compat mode), add to pointer.
// - long displacement: pointer plus extension word, pointer kept.
// - PC-relative modes add a displacement to PC with linear arithmetic.
// - short PC-relative: nine-bit field sign-extended and added to PC.
// - long PC-relative: PC plus extension word.
// - pointer PC-relative: PC plus pointer, pointer kept.
// - short immediates zero-extend eight or twelve bit fields.
// - long immediate and long absolute modes use the extension word as value or address.
// - absolute short: six-bit field zero-extended to the address.
// - short jump: twelve-bit field zero-extended to 24 bits.
// - I/O short: six-bit field with all upper bits set to one.
// - modifier low half zero selects reverse-carry arithmetic, upper byte ignored.
// - modifier 0x0001 to 0x7FFF selects modulo value plus one.
// - bit15 set, bit14 clear, low bits 2^k-1 select multiple wrap-around.
// - low half all ones selects linear; other codes are reserved.
// - every indirect mode works with every arithmetic type.
// - reset loads every modifier with all ones.
// - reverse-carry adds bit-reversed operands and reverses the sum.
// - modulo wraps past top to base and below base to top.
// - multiple wrap-around wraps correctly for offsets larger than modulus.
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH
`define EAG_AW         24
`define EAG_NPTR       8
`define EAG_IDXW       3
`define EAG_FIELD_W    12
`define EAG_MOD_RESET  24'hFFFFFF
`define EAG_MOD_LINEAR 16'hFFFF
`define EAG_MOD_REVC   16'h0000
`define EAG_MWA_W      14
`define EAG_SDISP_W    7
`define EAG_SC_W       16
`define EAG_PCDISP_W   9
`define EAG_IMM8_W     8
`define EAG_IMM12_W    12
`define EAG_ABS_W      6
`define EAG_JMP_W      12
`define EAG_IO_W       6
`endif

// [src/eag_pkg.sv]
// Types and modifier decode for the effective address generator
`include "eag_defs.svh"
package eag_pkg;
    typedef enum logic [4:0] {
        eag_m_noupd, eag_m_postinc1, eag_m_postdec1, eag_m_postincn,
        eag_m_postdecn, eag_m_indexn, eag_m_predec, eag_m_sdisp,
        eag_m_ldisp, eag_m_pc_short, eag_m_pc_long, eag_m_pc_reg,
        eag_m_imm8, eag_m_imm12, eag_m_imm_long, eag_m_abs_long,
        eag_m_abs_short, eag_m_jump_short, eag_m_io_short
    } eag_mode_t;

    typedef enum logic [2:0] {
        eag_ar_linear, eag_ar_revc, eag_ar_mod, eag_ar_mwa, eag_ar_rsvd
    } eag_arith_t;

    typedef enum logic [1:0] {
        eag_wr_ptr, eag_wr_ofs, eag_wr_mod
    } eag_wrsel_t;

    // only the low half decides; upper byte is free storage
    function automatic eag_arith_t eag_decode_mod(input logic [15:0] m);
        logic [`EAG_MWA_W-1:0] lo;
        lo = m[`EAG_MWA_W-1:0];
        if (m == `EAG_MOD_LINEAR) begin
            return eag_ar_linear;
        end else if (m == `EAG_MOD_REVC) begin
            return eag_ar_revc;
        end else if (!m[15]) begin
            return eag_ar_mod;
        end else if (!m[14] && lo != '0 && (lo & (lo + 14'h1)) == '0) begin
            return eag_ar_mwa;
        end else begin
            return eag_ar_rsvd;
        end
    endfunction
endpackage

// [src/eag_arith_if.sv]
// Carrier between the address core and its modifier arithmetic unit
`include "eag_defs.svh"
interface eag_arith_if;
    logic [`EAG_AW-1:0]  base_val;
    logic [`EAG_AW-1:0]  step;
    logic [`EAG_AW-1:0]  modifier;
    logic                dec;
    logic [`EAG_AW-1:0]  result;
    eag_pkg::eag_arith_t kind;
    modport core (output base_val, step, modifier, dec, input result, kind);
    modport unit (input base_val, step, modifier, dec, output result, kind);
endinterface

// [src/eag_modarith.sv]
// Pointer update arithmetic selected by the modifier value
`include "eag_defs.svh"
module eag_modarith (
    eag_arith_if.unit ar
);
    import eag_pkg::*;

    function automatic logic [`EAG_AW-1:0] bitrev(input logic [`EAG_AW-1:0] v);
        logic [`EAG_AW-1:0] r;
        r = '0;
        for (int i = 0; i < `EAG_AW; i++) begin
            r[i] = v[`EAG_AW-1-i];
        end
        return r;
    endfunction

    logic [15:0]        mlo;
    logic [15:0]        mask;
    logic [`EAG_AW-1:0] maskx;
    logic [`EAG_AW-1:0] mwmask;
    logic [`EAG_AW-1:0] lin;
    logic [`EAG_AW-1:0] rc;
    logic [`EAG_AW-1:0] modr;
    logic [`EAG_AW-1:0] mwa;
    logic signed [24:0] off_s;
    logic signed [24:0] delta;
    logic signed [24:0] modu;

    always_comb begin
        mlo      = ar.modifier[15:0];
        ar.kind  = eag_decode_mod(mlo);
        lin      = ar.dec ? ar.base_val - ar.step : ar.base_val + ar.step;
        // carry runs msb to lsb: add in the mirrored domain
        rc = bitrev(ar.dec ? bitrev(ar.base_val) - bitrev(ar.step)
                           : bitrev(ar.base_val) + bitrev(ar.step));
        // smallest 2^k-1 covering the modulus minus one
        mask  = mlo | (mlo >> 1);
        mask  = mask | (mask >> 2);
        mask  = mask | (mask >> 4);
        mask  = mask | (mask >> 8);
        maskx = {8'h00, mask};
        modu  = $signed({9'h000, mlo}) + 25'sd1;
        delta = $signed({ar.step[`EAG_AW-1], ar.step});
        if (ar.dec) begin
            delta = -delta;
        end
        off_s = $signed({1'b0, ar.base_val & maskx}) + delta;
        // whole-block steps move to the same spot in another buffer
        if ((ar.step & maskx) == '0) begin
            modr = lin;
        end else if (off_s < 0) begin
            modr = (ar.base_val & ~maskx) | 24'(off_s + modu);
        end else if (off_s >= modu) begin
            modr = (ar.base_val & ~maskx) | 24'(off_s - modu);
        end else begin
            modr = (ar.base_val & ~maskx) | off_s[`EAG_AW-1:0];
        end
        // masked add wraps any number of times
        mwmask = {{(`EAG_AW-`EAG_MWA_W){1'b0}}, mlo[`EAG_MWA_W-1:0]};
        mwa    = (ar.base_val & ~mwmask) | (lin & mwmask);
        case (ar.kind)
            eag_ar_revc: ar.result = rc;
            eag_ar_mod:  ar.result = modr;
            eag_ar_mwa:  ar.result = mwa;
            default:     ar.result = lin;
        endcase
    end
endmodule // eag_modarith

// [bench/eag_decoder_model.sv]
// Decoder stand-in that drives requests and register loads into the generator
`include "eag_defs.svh"
module eag_decoder_model import eag_pkg::*; (
    input  wire logic                    ref_clk,
    output logic                         req_valid,
    output eag_pkg::eag_mode_t           req_mode,
    output logic [`EAG_IDXW-1:0]         req_ptr,
    output logic [`EAG_FIELD_W-1:0]      req_field,
    output logic [`EAG_AW-1:0]           req_ext,
    output logic [`EAG_AW-1:0]           req_pc,
    output logic                         sixteen_bit_compat_mode,
    output logic                         wr_en,
    output eag_pkg::eag_wrsel_t          wr_sel,
    output logic [`EAG_IDXW-1:0]         wr_idx,
    output logic [`EAG_AW-1:0]           wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid = 1'b0;
        req_mode = eag_m_noupd;
        req_ptr = 3'h0;
        req_field = 12'h0;
        req_ext = 24'h0;
        req_pc = 24'h0;
        sixteen_bit_compat_mode = 1'b0;
        wr_en = 1'b0;
        wr_sel = eag_wr_ptr;
        wr_idx = 3'h0;
        wr_data = 24'h0;
    end

    task automatic load(input eag_wrsel_t sel, input logic [2:0] idx, input logic [23:0] val);
        @(negedge ref_clk);
        req_valid = 1'b0;
        wr_en = 1'b1;
        wr_sel = sel;
        wr_idx = idx;
        wr_data = val;
    endtask

    // stays valid on return, so two calls in a row give back-to-back requests
    task automatic send(input eag_mode_t mode, input logic [2:0] ptr, input logic [11:0] f,
                        input logic [23:0] ext, input logic [23:0] pc, input logic sc);
        @(negedge ref_clk);
        wr_en = 1'b0;
        wr_data = ~wr_data;
        req_valid = 1'b1;
        req_mode = mode;
        req_ptr = ptr;
        req_field = f;
        req_ext = ext;
        req_pc = pc;
        sixteen_bit_compat_mode = sc;
    endtask

    // with the qualifiers released, field, extension and write data flip so a stale value can never pass as fresh
    task automatic idle();
        @(negedge ref_clk);
        req_valid = 1'b0;
        wr_en = 1'b0;
        req_field = ~req_field;
        req_ext = ~req_ext;
        wr_data = ~wr_data;
    endtask
endmodule // eag_decoder_model

// [bench/eag_bench.sv]
// Self-checking bench for the effective address generator
`include "eag_defs.svh"
module eag_bench import eag_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        eag_mode_t   mode;
        logic [23:0] m, r, n;
        logic [11:0] f;
        logic [23:0] x;
        logic        sc;
        logic [23:0] ea;
        logic        wbv;
        logic [23:0] wbd;
        logic        dat;
    } eag_row_t;

    localparam logic [23:0] lin = 24'hFFFFFF;
    localparam logic [23:0] pc0 = 24'h1000;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    int   err_total = 0;
    int   checks = 0;
    logic req_valid, sixteen_bit_compat_mode, wr_en;
    eag_mode_t   req_mode;
    eag_wrsel_t  wr_sel;
    logic [2:0]  req_ptr, wr_idx, wb_idx_q;
    logic [11:0] req_field;
    logic [23:0] req_ext, req_pc, wr_data, ea_q, wb_data_q;
    logic        ea_valid_q, ea_is_data_q, wb_valid_q;

    eag_row_t rows [0:30] = '{
        '{eag_m_noupd, lin, 24'h100, 24'h55, 12'h0, 24'h0, 1'b0,
            24'h100, 1'b0, 24'h0, 1'b0},
        '{eag_m_postinc1, lin, 24'h100, 24'h55, 12'h0, 24'h0, 1'b0,
            24'h100, 1'b1, 24'h101, 1'b0},
        '{eag_m_postdec1, lin, 24'h0, 24'h55, 12'h0, 24'h0, 1'b0,
            24'h0, 1'b1, lin, 1'b0},
        '{eag_m_postincn, lin, 24'h100, 24'h10, 12'h0, 24'h0, 1'b0,
            24'h100, 1'b1, 24'h110, 1'b0},
        '{eag_m_postdecn, lin, 24'h100, 24'h10, 12'h0, 24'h0, 1'b0,
            24'h100, 1'b1, 24'hF0, 1'b0},
        '{eag_m_indexn, lin, 24'h100, 24'h10, 12'h0, 24'h0, 1'b0,
            24'h110, 1'b0, 24'h0, 1'b0},
        '{eag_m_predec, lin, 24'h100, 24'h10, 12'h0, 24'h0, 1'b0,
            24'hFF, 1'b1, 24'hFF, 1'b0},
        '{eag_m_sdisp, lin, 24'h100, 24'h10, 12'h7F, 24'h0, 1'b0,
            24'hFF, 1'b0, 24'h0, 1'b0},
        '{eag_m_sdisp, lin, 24'h100, 24'h10, 12'hF40, 24'h0, 1'b1,
            24'h100C0, 1'b0, 24'h0, 1'b0},
        '{eag_m_ldisp, lin, 24'h100, 24'h10, 12'h0, 24'h1000, 1'b0,
            24'h1100, 1'b0, 24'h0, 1'b0},
        '{eag_m_pc_short, 24'h0, 24'h100, 24'h10, 12'h100, 24'h0, 1'b0,
            24'hF00, 1'b0, 24'h0, 1'b0},
        '{eag_m_pc_long, 24'h7, 24'h100, 24'h10, 12'h0, lin, 1'b0,
            24'hFFF, 1'b0, 24'h0, 1'b0},
        '{eag_m_pc_reg, 24'h7, 24'h20, 24'h10, 12'h0, 24'h0, 1'b0,
            24'h1020, 1'b0, 24'h0, 1'b0},
        '{eag_m_imm8, lin, 24'h0, 24'h0, 12'hFAB, 24'h0, 1'b0,
            24'hAB, 1'b0, 24'h0, 1'b1},
        '{eag_m_imm12, lin, 24'h0, 24'h0, 12'hFAB, 24'h0, 1'b0,
            24'hFAB, 1'b0, 24'h0, 1'b1},
        '{eag_m_imm_long, lin, 24'h0, 24'h0, 12'h0, 24'h123456, 1'b0,
            24'h123456, 1'b0, 24'h0, 1'b1},
        '{eag_m_abs_long, lin, 24'h0, 24'h0, 12'h0, 24'hABCD, 1'b0,
            24'hABCD, 1'b0, 24'h0, 1'b0},
        '{eag_m_abs_short, lin, 24'h0, 24'h0, 12'hFFF, 24'h0, 1'b0,
            24'h3F, 1'b0, 24'h0, 1'b0},
        '{eag_m_jump_short, lin, 24'h0, 24'h0, 12'hFFF, 24'h0, 1'b0,
            24'hFFF, 1'b0, 24'h0, 1'b0},
        '{eag_m_io_short, lin, 24'h0, 24'h0, 12'h015, 24'h0, 1'b0,
            24'hFFFFD5, 1'b0, 24'h0, 1'b0},
        '{eag_m_postinc1, 24'h7, 24'h107, 24'h0, 12'h0, 24'h0, 1'b0,
            24'h107, 1'b1, 24'h100, 1'b0},
        '{eag_m_postdec1, 24'h7, 24'h100, 24'h0, 12'h0, 24'h0, 1'b0,
            24'h100, 1'b1, 24'h107, 1'b0},
        '{eag_m_postinc1, 24'hAB7FFF, 24'h7FFF, 24'h0, 12'h0, 24'h0, 1'b0,
            24'h7FFF, 1'b1, 24'h0, 1'b0},
        '{eag_m_postincn, 24'hAB0000, 24'h8, 24'h8, 12'h0, 24'h0, 1'b0,
            24'h8, 1'b1, 24'h4, 1'b0},
        '{eag_m_postincn, 24'h8007, 24'h106, 24'h13, 12'h0, 24'h0, 1'b0,
            24'h106, 1'b1, 24'h101, 1'b0},
        '{eag_m_postdecn, 24'h8007, 24'h101, 24'h13, 12'h0, 24'h0, 1'b0,
            24'h101, 1'b1, 24'h106, 1'b0},
        '{eag_m_indexn, 24'h8003, 24'h102, 24'h7, 12'h0, 24'h0, 1'b0,
            24'h101, 1'b0, 24'h0, 1'b0},
        '{eag_m_postincn, 24'h4, 24'h104, 24'h3, 12'h0, 24'h0, 1'b0,
            24'h104, 1'b1, 24'h102, 1'b0},
        '{eag_m_postinc1, 24'h12FFFF, lin, 24'h0, 12'h0, 24'h0, 1'b0,
            lin, 1'b1, 24'h0, 1'b0},
        '{eag_m_postinc1, 24'hC000, 24'h10, 24'h0, 12'h0, 24'h0, 1'b0,
            24'h10, 1'b1, 24'h11, 1'b0},
        '{eag_m_predec, 24'h7, 24'h100, 24'h0, 12'h0, 24'h0, 1'b0,
            24'h107, 1'b1, 24'h107, 1'b0}
    };

    always #4 ref_clk = ~ref_clk;

    eag_decoder_model u_dec (.ref_clk(ref_clk), .req_valid(req_valid), .req_mode(req_mode),
        .req_ptr(req_ptr), .req_field(req_field), .req_ext(req_ext), .req_pc(req_pc),
        .sixteen_bit_compat_mode(sixteen_bit_compat_mode), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_idx(wr_idx), .wr_data(wr_data));

    eag_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_mode(req_mode), .req_ptr(req_ptr), .req_field(req_field), .req_ext(req_ext),
        .req_pc(req_pc), .sixteen_bit_compat_mode(sixteen_bit_compat_mode), .wr_en(wr_en),
        .wr_sel(wr_sel), .wr_idx(wr_idx), .wr_data(wr_data), .ea_valid_q(ea_valid_q),
        .ea_q(ea_q), .ea_is_data_q(ea_is_data_q), .wb_valid_q(wb_valid_q),
        .wb_idx_q(wb_idx_q), .wb_data_q(wb_data_q));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        arst_n = 1'b0;
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
    endtask

    // one answer checked on the cycle it stands
    task automatic expect_out(input logic [23:0] ea, input logic wbv, input logic [23:0] wbd);
        check(24'(ea_valid_q), 24'h1);
        check(ea_q, ea);
        check(24'(wb_valid_q), 24'(wbv));
        if (wbv) begin
            check(wb_data_q, wbd);
        end
    endtask

    initial begin
        do_reset();
        foreach (rows[i]) begin
            u_dec.load(eag_wr_ptr, 3'(i), rows[i].r);
            u_dec.load(eag_wr_ofs, 3'(i), rows[i].n);
            u_dec.load(eag_wr_mod, 3'(i), rows[i].m);
            u_dec.send(rows[i].mode, 3'(i), rows[i].f, rows[i].x, pc0, rows[i].sc);
            u_dec.idle();
            expect_out(rows[i].ea, rows[i].wbv, rows[i].wbd);
            check(24'(ea_is_data_q), 24'(rows[i].dat));
            if (rows[i].wbv) begin
                check(24'(wb_idx_q), 24'(i % 8));
            end
        end
        // back-to-back on one pointer: the second must see the first write-back
        u_dec.load(eag_wr_ptr, 3'h3, 24'h50);
        u_dec.load(eag_wr_mod, 3'h3, lin);
        u_dec.send(eag_m_postinc1, 3'h3, 12'h0, 24'h0, pc0, 1'b0);
        u_dec.send(eag_m_postinc1, 3'h3, 12'h0, 24'h0, pc0, 1'b0);
        expect_out(24'h50, 1'b1, 24'h51);
        u_dec.send(eag_m_predec, 3'h3, 12'h0, 24'h0, pc0, 1'b0);
        expect_out(24'h51, 1'b1, 24'h52);
        u_dec.send(eag_m_noupd, 3'h3, 12'h0, 24'h0, pc0, 1'b0);
        expect_out(24'h51, 1'b1, 24'h51);
        u_dec.idle();
        expect_out(24'h51, 1'b0, 24'h0);
        u_dec.idle();
        check(24'(ea_valid_q), 24'h0);
        check(ea_q, 24'h0);
        // a modulo modifier left behind must not survive a second reset
        u_dec.load(eag_wr_mod, 3'h5, 24'h7);
        u_dec.idle();
        do_reset();
        check(24'(ea_valid_q), 24'h0);
        u_dec.send(eag_m_noupd, 3'h6, 12'h0, 24'h0, pc0, 1'b0);
        u_dec.idle();
        expect_out(24'h0, 1'b0, 24'h0);
        u_dec.load(eag_wr_ptr, 3'h5, lin);
        u_dec.send(eag_m_postinc1, 3'h5, 12'h0, 24'h0, pc0, 1'b0);
        u_dec.idle();
        expect_out(lin, 1'b1, 24'h0);
        stop_test();
    end

    // about 200 cycles are needed; a generous margin before calling it a hang
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule // eag_bench
